/* File: src/tsq_device.sv */
// Overview of operation
// [RULE1] Mode 100: empty until trigger, then overwrite
// [RULE2] Trigger sources need detector and routing bit
// [RULE3] First edge switches phase until bypass; code clears it on any mode write
// [RULE4] Continuous phase raises full on full/overrun
// [RULE5] Mode 111: empty until trigger, then stop
// [RULE6] Bypass-then-stop sets full and stops storing
// [RULE7] Mode 010: capped overwrite, then full stop
// [RULE8] Capped phase depth is threshold, full masked; code uses depth 1 when threshold is 0
// [RULE9] No full flag during capped phase
// [RULE10] After trigger uncap, unmask, stop at full
// [RULE11] Tag read moves oldest word to buffer
// [RULE12] Read frees slot, next oldest presented
// [RULE13] Nine-bit word count across two registers
// [RULE14] Empty read returns dedicated empty tag
// [RULE15] Host reads whole words from tag byte
// [RULE16] Burst address wraps last byte to tag
// [RULE17] Host drains with count plus N words
// [RULE18] Host configures event, batching, then mode
// [RULE19] Mode 000 clears queue and keeps empty
// [RULE20] Continuous full: overwrite oldest data
// [RULE21] Stop mode full: keep content unchanged
// [RULE22] Trigger is OR of routed events, once
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module tsq_device
   import tsq_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   tsq_link_if.dev                link,
   input  wire logic              sample_valid,
   input  wire logic [7:0]        sample_tag,
   input  wire logic [47:0]       sample_data,
   input  wire logic [EVT_N-1:0]  event_in,
   output logic                   queue_full_flag,
   output logic                   triggered,
   output logic [CNT_W-1:0]       word_count
);
   typedef struct packed {
      logic [DEPTH-1:0][WORD_W-1:0] mem;
      logic [WORD_W-1:0]            obuf;
      logic [PTR_W-1:0]             wr_ptr;
      logic [PTR_W-1:0]             rd_ptr;
      logic [CNT_W-1:0]             count;
      tsq_mode_t                    mode;
      logic [7:0]                   thr;
      logic [EVT_N-1:0]             route;
      logic                         trig_prev;
      logic                         triggered;
      logic                         full_flag;
      logic [ADDR_W-1:0]            addr;
      logic                         ack;
      logic [7:0]                   rdata;
   } tsq_dev_state_t;

   tsq_dev_state_t    s_q;
   tsq_dev_state_t    s_d;
   logic              trig;
   logic              trig_edge;
   logic              pre_trig;
   logic              is_trig_mode;
   logic              collect;
   logic              overwrite;
   logic              masked;
   logic [CNT_W-1:0]  cap;
   logic              take;
   logic [ADDR_W-1:0] acc_addr;
   logic [WORD_W-1:0] head;

   // Burst addressing: data window wraps from last byte back to tag
   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
      if (a == ADDR_OUT_LAST) begin
         return ADDR_OUT_TAG;
      end
      return a + 7'h01;
   endfunction

   function automatic logic [7:0] word_byte(input logic [WORD_W-1:0] w,
                                            input logic [ADDR_W-1:0] a);
      logic [2:0] idx;
      idx = 3'(a - ADDR_OUT_TAG);
      return w[{idx, 3'b000} +: 8];
   endfunction

   always_comb begin
      trig         = |(event_in & s_q.route);                            // [RULE2] [RULE22]
      trig_edge    = trig && !s_q.trig_prev;                             // [RULE3] [RULE22]
      pre_trig     = !s_q.triggered;
      is_trig_mode = (s_q.mode == TSQ_B2C) || (s_q.mode == TSQ_B2S) ||
                     (s_q.mode == TSQ_CWTM) || (s_q.mode == TSQ_C2S);
      collect      = (s_q.mode != TSQ_BYPASS) &&
                     !(((s_q.mode == TSQ_B2C) || (s_q.mode == TSQ_B2S)) && pre_trig); // [RULE1] [RULE5]
      overwrite    = (s_q.mode == TSQ_CONT) || (s_q.mode == TSQ_B2C) ||
                     (((s_q.mode == TSQ_C2S) || (s_q.mode == TSQ_CWTM)) && pre_trig); // [RULE20]
      masked       = (s_q.mode == TSQ_CWTM) && pre_trig;                 // [RULE7] [RULE8] [RULE10]
      if (masked) begin
         cap = (s_q.thr == 8'h00) ? 9'h001 : {1'b0, s_q.thr};           // [RULE8]
      end else begin
         cap = DEPTH_CNT;                                                // [RULE10]
      end
      take     = link.req && !s_q.ack;
      acc_addr = link.burst ? next_addr(s_q.addr) : link.addr;           // [RULE16]
      if (s_q.count != 9'h000) begin
         head = s_q.mem[s_q.rd_ptr];                                     // [RULE12]
      end else begin
         head = {48'h0, EMPTY_TAG};                                      // [RULE14]
      end
   end

   always_comb begin
      s_d           = s_q;
      s_d.ack       = 1'b0;
      s_d.trig_prev = trig;
      if (is_trig_mode && trig_edge && pre_trig) begin
         s_d.triggered = 1'b1;                                           // [RULE3] [RULE22]
      end

      if (take) begin
         s_d.ack  = 1'b1;
         s_d.addr = acc_addr;
         if (link.we) begin
            unique case (acc_addr)
               ADDR_CTRL_ONE: begin
                  s_d.thr = link.wdata;
               end
               ADDR_CTRL_FOUR: begin
                  s_d.mode      = tsq_mode_t'(link.wdata[MODE_LSB +: 3]);
                  s_d.triggered = 1'b0;                                  // [RULE22]
               end
               ADDR_ROUTING: begin
                  s_d.route = link.wdata[EVT_N-1:0];
               end
               default: begin
               end
            endcase
         end else begin
            if (acc_addr == ADDR_STAT_LO) begin
               s_d.rdata = s_q.count[7:0];                               // [RULE13]
            end else if (acc_addr == ADDR_STAT_HI) begin
               s_d.rdata = {s_q.full_flag, s_q.triggered, 5'h00,
                            s_q.count[8]};                               // [RULE13]
            end else if (acc_addr == ADDR_CTRL_ONE) begin
               s_d.rdata = s_q.thr;
            end else if (acc_addr == ADDR_CTRL_FOUR) begin
               s_d.rdata = {5'h00, s_q.mode};
            end else if (acc_addr == ADDR_ROUTING) begin
               s_d.rdata = {3'h0, s_q.route};
            end else if (acc_addr == ADDR_OUT_TAG) begin
               s_d.obuf  = head;                                         // [RULE11] [RULE14]
               s_d.rdata = head[7:0];
               if (s_q.count != 9'h000) begin
                  s_d.rd_ptr    = s_q.rd_ptr + 8'h01;                    // [RULE12]
                  s_d.count     = s_q.count - 9'h001;
                  s_d.full_flag = 1'b0;
               end
            end else if ((acc_addr > ADDR_OUT_TAG) && (acc_addr <= ADDR_OUT_LAST)) begin
               s_d.rdata = word_byte(s_q.obuf, acc_addr);                // [RULE11]
            end else begin
               s_d.rdata = 8'h00;
            end
         end
      end

      // Store after any pop, so a full flag set here wins over the clear
      if (sample_valid && collect) begin
         if (s_d.count < cap) begin
            s_d.mem[s_q.wr_ptr] = {sample_data, sample_tag};
            s_d.wr_ptr          = s_q.wr_ptr + 8'h01;
            s_d.count           = s_d.count + 9'h001;
            if ((s_d.count >= cap) && !masked) begin
               s_d.full_flag = 1'b1;                                     // [RULE4] [RULE6] [RULE9]
            end
         end else if (overwrite) begin
            s_d.mem[s_q.wr_ptr] = {sample_data, sample_tag};             // [RULE20]
            s_d.wr_ptr          = s_q.wr_ptr + 8'h01;
            s_d.rd_ptr          = s_d.rd_ptr + 8'h01;
            if (!masked) begin
               s_d.full_flag = 1'b1;                                     // [RULE4] [RULE9]
            end
         end else begin
            s_d.full_flag = 1'b1;                                        // [RULE6] [RULE21]
         end
      end

      if (s_q.mode == TSQ_BYPASS) begin
         s_d.count     = 9'h000;                                         // [RULE19]
         s_d.wr_ptr    = 8'h00;
         s_d.rd_ptr    = 8'h00;
         s_d.full_flag = 1'b0;
         s_d.triggered = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q       <= '0;
         s_q.mode  <= TSQ_BYPASS;
         s_q.thr   <= THR_RST;
         s_q.route <= ROUTE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.ack        = s_q.ack;
   assign link.rdata      = s_q.rdata;
   assign queue_full_flag = s_q.full_flag;
   assign triggered       = s_q.triggered;
   assign word_count      = s_q.count;
endmodule

/* File: src/tsq_host.sv */
`timescale 1ns/1ps
module tsq_host
   import tsq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   tsq_link_if.host         link,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   typedef struct packed {
      tsq_hstate_t       st;
      logic              req;
      logic              we;
      logic              burst;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              word_mode;
      logic [2:0]        idx;
      logic [WORD_W-1:0] word;
      logic [7:0]        last;
      logic              wb_ack;
      logic [31:0]       wb_dat;
   } tsq_host_state_t;

   tsq_host_state_t s_q;
   tsq_host_state_t s_d;
   logic            wb_take;

   always_comb begin
      s_d        = s_q;
      s_d.wb_ack = 1'b0;
      wb_take    = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
      if (wb_take) begin
         s_d.wb_ack = 1'b1;
         if (wb_we_i) begin
            if ((wb_adr_i == HWB_CMD) && (s_q.st == TSQ_H_IDLE) && (&wb_sel_i[2:0])) begin
               s_d.st  = TSQ_H_REQ;
               s_d.req = 1'b1;
               s_d.idx = 3'h0;
               if (wb_dat_i[CMD_WORD_BIT]) begin
                  s_d.word_mode = 1'b1;                                  // [RULE15]
                  s_d.addr      = ADDR_OUT_TAG;
                  s_d.we        = 1'b0;
                  s_d.burst     = 1'b0;
               end else begin
                  s_d.word_mode = 1'b0;
                  s_d.addr      = wb_dat_i[CMD_ADDR_LSB +: ADDR_W];
                  s_d.we        = wb_dat_i[CMD_WE_BIT];
                  s_d.burst     = wb_dat_i[CMD_BURST_BIT];
                  s_d.wdata     = wb_dat_i[CMD_WDATA_LSB +: 8];
               end
            end
         end else begin
            if (wb_adr_i == HWB_STATUS) begin
               s_d.wb_dat = {16'h0000, s_q.last, 7'h00, (s_q.st != TSQ_H_IDLE)};
            end else if (wb_adr_i == HWB_WORD_LO) begin
               s_d.wb_dat = s_q.word[31:0];
            end else if (wb_adr_i == HWB_WORD_HI) begin
               s_d.wb_dat = {8'h00, s_q.word[55:32]};
            end else begin
               s_d.wb_dat = 32'h0000_0000;
            end
         end
      end

      unique case (s_q.st)
         TSQ_H_IDLE: begin
         end
         TSQ_H_REQ: begin
            if (link.ack) begin
               s_d.req  = 1'b0;
               s_d.last = link.rdata;
               s_d.st   = TSQ_H_GAP;
               if (s_q.word_mode) begin
                  s_d.word[{s_q.idx, 3'b000} +: 8] = link.rdata;
               end
            end
         end
         TSQ_H_GAP: begin
            if (s_q.word_mode && (s_q.idx != WORD_LAST_IDX)) begin
               s_d.idx   = s_q.idx + 3'h1;
               s_d.burst = 1'b1;                                         // [RULE15] [RULE16]
               s_d.req   = 1'b1;
               s_d.st    = TSQ_H_REQ;
            end else begin
               s_d.st = TSQ_H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_q    <= '0;
         s_q.st <= TSQ_H_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.req   = s_q.req;
   assign link.we    = s_q.we;
   assign link.burst = s_q.burst;
   assign link.addr  = s_q.addr;
   assign link.wdata = s_q.wdata;
   assign wb_ack_o   = s_q.wb_ack;
   assign wb_dat_o   = s_q.wb_dat;
endmodule

/* File: src/tsq_link_if.sv */
`timescale 1ns/1ps
interface tsq_link_if;
   import tsq_pkg::*;
   logic              req;
   logic              we;
   logic              burst;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wdata;
   logic              ack;
   logic [7:0]        rdata;

   modport dev  (input req, input we, input burst, input addr, input wdata,
                 output ack, output rdata);
   modport host (output req, output we, output burst, output addr, output wdata,
                 input ack, input rdata);
endinterface

/* File: src/tsq_pkg.sv */
package tsq_pkg;
   // Queue geometry
   localparam int          DEPTH       = 256;
   localparam int          PTR_W       = 8;
   localparam int          CNT_W       = 9;
   localparam int          WORD_W      = 56;
   localparam int          ADDR_W      = 7;
   localparam int          EVT_N       = 5;
   localparam logic [8:0]  DEPTH_CNT   = 9'h100;

   // Device register addresses on the link
   localparam logic [6:0]  ADDR_CTRL_ONE  = 7'h07;
   localparam logic [6:0]  ADDR_CTRL_FOUR = 7'h0A;
   localparam logic [6:0]  ADDR_STAT_LO   = 7'h1B;
   localparam logic [6:0]  ADDR_STAT_HI   = 7'h1C;
   localparam logic [6:0]  ADDR_ROUTING   = 7'h5F;
   localparam logic [6:0]  ADDR_OUT_TAG   = 7'h78;
   localparam logic [6:0]  ADDR_OUT_LAST  = 7'h7E;

   // Field positions
   localparam int          MODE_LSB       = 0;
   localparam int          STAT_HI_CNT8   = 0;
   localparam int          STAT_HI_TRIG   = 6;
   localparam int          STAT_HI_FULL   = 7;
   localparam int          EVT_SINGLE_TAP = 0;
   localparam int          EVT_DOUBLE_TAP = 1;
   localparam int          EVT_FREE_FALL  = 2;
   localparam int          EVT_WAKE_UP    = 3;
   localparam int          EVT_ORIENT     = 4;

   // Values after reset and special codes
   localparam logic [7:0]  THR_RST        = 8'h00;
   localparam logic [4:0]  ROUTE_RST      = 5'h00;
   localparam logic [7:0]  EMPTY_TAG      = 8'hFF;

   typedef enum logic [2:0] {
      TSQ_BYPASS = 3'h0,
      TSQ_STOP   = 3'h1,
      TSQ_CWTM   = 3'h2,
      TSQ_C2S    = 3'h3,
      TSQ_B2C    = 3'h4,
      TSQ_CONT   = 3'h6,
      TSQ_B2S    = 3'h7
   } tsq_mode_t;

   // Host Wishbone register byte addresses
   localparam logic [7:0]  HWB_CMD        = 8'h00;
   localparam logic [7:0]  HWB_STATUS     = 8'h04;
   localparam logic [7:0]  HWB_WORD_LO    = 8'h08;
   localparam logic [7:0]  HWB_WORD_HI    = 8'h0C;
   localparam int          CMD_WDATA_LSB  = 0;
   localparam int          CMD_ADDR_LSB   = 8;
   localparam int          CMD_WE_BIT     = 16;
   localparam int          CMD_BURST_BIT  = 17;
   localparam int          CMD_WORD_BIT   = 18;
   localparam logic [2:0]  WORD_LAST_IDX  = 3'h6;

   typedef enum logic [2:0] {
      TSQ_H_IDLE = 3'b001,
      TSQ_H_REQ  = 3'b010,
      TSQ_H_GAP  = 3'b100
   } tsq_hstate_t;
endpackage

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench
   import tsq_pkg::*;
();
   logic clk_sys = 1'b0, arst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic              s_vld = 1'b0, wb_ack, full_o, trig_o;
   logic [7:0]        wb_adr = 8'h00, s_tag = 8'h00;
   logic [3:0]        wb_sel = 4'h0;
   logic [31:0]       wb_wd = 32'h0, wb_rd, r;
   logic [47:0]       s_dat = 48'h0;
   logic [EVT_N-1:0]  evt = 5'h00;
   logic [CNT_W-1:0]  cnt_o;
   logic [WORD_W-1:0] smp [0:511];
   logic [64:0]       notes [$];
   logic [64:0]       nt;
   int                miscompares = 0, cmp_count = 0, seed = 63, n = 0;

   tsq_link_if link ();
   tsq_device tsq_device_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(link.dev),
      .sample_valid(s_vld), .sample_tag(s_tag), .sample_data(s_dat), .event_in(evt),
      .queue_full_flag(full_o), .triggered(trig_o), .word_count(cnt_o));
   tsq_host tsq_host_i (.clk_sys(clk_sys), .arst_n(arst_n), .link(link.host),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack));
   tsq_checker tsq_checker_i (.clk_sys(clk_sys), .arst_n(arst_n), .req(link.req),
      .we(link.we), .burst(link.burst), .addr(link.addr), .wdata(link.wdata),
      .ack(link.ack), .rdata(link.rdata), .queue_full_flag(full_o),
      .triggered(trig_o), .word_count(cnt_o));

   always #25 clk_sys = ~clk_sys;

   // Each read answer is matched with the oldest note {check, expected, mask}
   always @(posedge clk_sys) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0) begin
         nt = notes.pop_front();
         if (nt[64]) begin
            cmp_count++;
            if ((wb_rd & nt[31:0]) !== nt[63:32]) begin
               miscompares++;
               $display("MISMATCH t=%0t got %h exp %h", $time, wb_rd & nt[31:0], nt[63:32]);
            end
         end
      end
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_wd  <= d;
      do @(posedge clk_sys); while (wb_ack !== 1'b1);
      r = wb_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e,
                     input logic [31:0] m);
      notes.push_back({c, e, m});
      wb(1'b0, a, 32'h0);
   endtask

   // Command layout: word read, burst, write, spare, address, data
   task automatic dev(input logic [18:0] c);
      wb(1'b1, HWB_CMD, {13'h0, c});
      do rd(HWB_STATUS, 1'b0, 32'h0, 32'h0); while (r[0] !== 1'b0);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      dev({4'b0010, a, v});
   endtask

   task automatic chk_reg(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
      dev({4'b0000, a, 8'h00});
      rd(HWB_STATUS, 1'b1, {16'h0, e, 8'h00}, {16'h0, m, 8'h00});
   endtask

   task automatic chk_word(input logic [55:0] e);
      dev(19'h40000);
      rd(HWB_WORD_LO, 1'b1, e[31:0], 32'hFFFFFFFF);
      rd(HWB_WORD_HI, 1'b1, {8'h00, e[55:32]}, 32'h00FFFFFF);
   endtask

   task automatic mode(input logic [2:0] m);
      wr(ADDR_CTRL_FOUR, 8'h00);
      wr(ADDR_CTRL_FOUR, {5'h00, m});
      n = 0;
   endtask

   task automatic push(input int k);
      repeat (k) begin
         smp[n] = 56'({$random(seed), $random(seed)});
         smp[n][7] = 1'b0;
         s_vld <= 1'b1;
         s_tag <= smp[n][7:0];
         s_dat <= smp[n][55:8];
         n++;
         @(posedge clk_sys);
      end
      s_vld <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic fire(input int k);
      evt <= 5'h01 << k;
      repeat (2) @(posedge clk_sys);
      evt <= 5'h00;
      @(posedge clk_sys);
   endtask

   initial begin
      #2_000_000;
      miscompares++;
      stop_test();
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk_reg(ADDR_STAT_LO, 8'hFF, 8'h00);
      for (int k = 0; k < EVT_N; k++) begin
         wr(ADDR_ROUTING, 8'h01 << k);
         mode(TSQ_B2C);
         push(2);
         fire((k + 1) % EVT_N);
         chk_reg(ADDR_STAT_HI, 8'hC1, 8'h00);
         fire(k);
         push(2);
         chk_reg(ADDR_STAT_HI, 8'hC1, 8'h40);
         chk_reg(ADDR_STAT_LO, 8'hFF, 8'h02);
         chk_word(smp[2]);
         chk_word(smp[3]);
         chk_word({48'h0, EMPTY_TAG});
      end
      wr(ADDR_ROUTING, 8'h01 << EVT_WAKE_UP);
      mode(TSQ_B2C);
      fire(EVT_WAKE_UP);
      push(258);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'hC1);
      chk_word(smp[2]);
      dev(19'h20000);
      rd(HWB_STATUS, 1'b1, {16'h0, smp[3][7:0], 8'h00}, 32'h0000FF00);
      chk_word(smp[4]);
      chk_reg(ADDR_STAT_LO, 8'hFF, 8'hFD);
      mode(TSQ_B2S);
      push(3);
      fire(EVT_WAKE_UP);
      push(257);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'hC1);
      chk_word(smp[3]);
      wr(ADDR_CTRL_ONE, 8'h04);
      mode(TSQ_CWTM);
      push(10);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'h00);
      chk_reg(ADDR_STAT_LO, 8'hFF, 8'h04);
      chk_word(smp[6]);
      fire(EVT_WAKE_UP);
      push(300);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'hC1);
      chk_word(smp[7]);
      mode(TSQ_CONT);
      push(258);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'h81);
      chk_word(smp[2]);
      mode(TSQ_STOP);
      push(257);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'h81);
      chk_word(smp[0]);
      mode(TSQ_C2S);
      push(258);
      fire(EVT_WAKE_UP);
      push(2);
      chk_reg(ADDR_STAT_HI, 8'hC1, 8'hC1);
      chk_word(smp[2]);
      chk_reg(ADDR_CTRL_FOUR, 8'h07, 8'h03);
      chk_reg(ADDR_CTRL_ONE, 8'hFF, 8'h04);
      chk_reg(ADDR_ROUTING, 8'h1F, 8'h08);
      wr(ADDR_CTRL_FOUR, 8'h00);
      chk_reg(ADDR_STAT_LO, 8'hFF, 8'h00);
      stop_test();
   end
endmodule

/* File: verif/tsq_properties.sv */
`timescale 1ns/1ps
module tsq_checker
   import tsq_pkg::*;
(
   input logic              clk_sys,
   input logic              arst_n,
   input logic              req,
   input logic              we,
   input logic              burst,
   input logic [ADDR_W-1:0] addr,
   input logic [7:0]        wdata,
   input logic              ack,
   input logic [7:0]        rdata,
   input logic              queue_full_flag,
   input logic              triggered,
   input logic [CNT_W-1:0]  word_count
);
   logic [2:0] mode_q;

   // Mode code as last written over the link
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= 3'h0;
      end else if (req && we && !burst && ack && addr == ADDR_CTRL_FOUR) begin
         mode_q <= wdata[2:0];
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   AST_LINK_ANSWER: assert property (req && !ack |=> ack)
      else $error("link request not answered in next cycle");
   AST_ACK_PULSE: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   AST_RDATA_HOLD: assert property ($changed(rdata) |-> ack)
      else $error("read data changed without ack");
   AST_BYPASS_EMPTY: assert property ((mode_q == 3'h0) [*3] |->
      word_count == 0 && !queue_full_flag && !triggered)
      else $error("queue not empty in bypass");
   AST_COUNT_MAX: assert property (word_count <= DEPTH_CNT)
      else $error("word count above depth");
   AST_NO_TRIG: assert property ((!(mode_q inside {3'h2, 3'h3, 3'h4, 3'h7})) [*2]
      |-> !triggered)
      else $error("trigger latched in untriggered mode");
   AST_TRIG_STICKY: assert property (triggered && !(req && we && !ack
      && addr == ADDR_CTRL_FOUR) |=> triggered)
      else $error("trigger dropped without mode write");
   AST_CAP_NO_FULL: assert property (mode_q == TSQ_CWTM && !triggered
      |=> !$rose(queue_full_flag) || triggered)
      else $error("full flag raised in capped phase");
   AST_FULL_AT_DEPTH: assert property ($rose(queue_full_flag)
      && (mode_q == TSQ_B2S || mode_q == TSQ_CWTM) |-> word_count == DEPTH_CNT)
      else $error("stop phase full flag below depth");
   AST_PRE_TRIG_EMPTY: assert property ((mode_q inside {3'h4, 3'h7} && !triggered) [*2]
      |-> word_count == 0)
      else $error("words stored before trigger");
endmodule
